/* rtl/ftcr_cfg_regs.sv */
// Fan pulse, temperature format and pin configuration register bank
`timescale 1ns/1ns
// Overview of operation
// - Two-bit code picks pulses per measurement: 00 one up to 11 four.
// - Fans one to four sit in bits 1:0 to 7:6; reset 0x55.
// - Format bit one selects twos complement, zero selects offset-64.
// - Temperature readings decode with the current format at once.
// - Offset range bit: zero half-degree steps, one whole-degree steps.
// - Shared pin direction bit: zero input, one output.
// - Shared pin polarity bit: zero active low, one active high.
// - Bit 4 picks CPU voltage code or general I/O on five pins.
// - Bits 5 to 7 let each channel drive the overtemperature pin.
// - Minimum-code limit in the current format silences that channel.
// - Mux pin: fan 4 tach, overtemp, alert output, or general I/O.
// - Output disable bit stops overtemperature output on every channel.
// - On overtemperature fans go full speed, or stored maxima if selected.
// - Bits 4 to 7 bypass rail attenuators for a 2.25 V scale.
// - Lock bit set makes both configuration registers ignore writes.
// - Power-on values 0x01 and 0x00 for the two configuration registers.
module ftcr_cfg_regs
   import ftcr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Internal register port from the serial interface
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_en_i,
   input wire logic [7:0] reg_wr_data_i,
   input wire logic cfg_lock_i,
   output logic [7:0] reg_rd_data_o,
   // Fan tachometers and periods
   input wire logic [2:0] fan_tach_i,
   output logic [63:0] fan_period_o,
   output logic [3:0] fan_period_valid_o,
   // Temperature readings and offsets
   input wire logic [23:0] temp_raw_i,
   output logic [26:0] temp_c_o,
   input wire logic [23:0] offset_raw_i,
   output logic [29:0] offset_half_o,
   // Overtemperature comparison
   input wire logic [2:0] chan_hot_i,
   input wire logic [23:0] overtemp_limit_i,
   output logic overtemp_asserted_o,
   // Dedicated overtemperature pin (open drain)
   input wire logic overtemp_pin_i,
   output logic overtemp_pin_o,
   output logic overtemp_pin_oe_n_o,
   // Multiplexed pin
   input wire logic mux_pin_i,
   output logic mux_pin_o,
   output logic mux_pin_oe_n_o,
   input wire logic alert_req_i,
   input wire logic shared_io_data_i,
   output logic shared_io_level_o,
   // Fan drive
   input wire logic [23:0] pwm_duty_i,
   input wire logic [23:0] max_duty_i,
   output logic [23:0] pwm_duty_o,
   // Analog front end controls
   output logic cpu_code_or_io_sel_o,
   output logic bypass_low_rail_atten_o,
   output logic bypass_core_rail_atten_o,
   output logic bypass_mid_rail_atten_o,
   output logic bypass_high_rail_atten_o
);
   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   function automatic logic [8:0] decode_temp(input logic [7:0] raw,
                                              input logic twos);
      logic [8:0] r;
      r = twos ? {raw[7], raw} : ({1'b0, raw} - FTCR_OFS64_BIAS);
      return r;
   endfunction : decode_temp

   function automatic logic [9:0] scale_offset(input logic [7:0] raw,
                                               input logic coarse);
      logic [9:0] r;
      r = coarse ? {raw[7], raw, 1'b0} : {raw[7], raw[7], raw};
      return r;
   endfunction : scale_offset

   // ---------------- Register file ----------------
   logic [7:0] pulse_cfg_r, pulse_cfg_nxt;
   logic [7:0] temp_pin_cfg_r, temp_pin_cfg_nxt;
   logic [7:0] pin_func_cfg_r, pin_func_cfg_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;

   always_comb begin
      pulse_cfg_nxt = pulse_cfg_r;
      temp_pin_cfg_nxt = temp_pin_cfg_r;
      pin_func_cfg_nxt = pin_func_cfg_r;
      if (reg_wr_en_i) begin
         case (reg_addr_i)
            FTCR_OFS_PULSE: pulse_cfg_nxt = reg_wr_data_i;
            FTCR_OFS_TEMP_PIN: begin
               if (!cfg_lock_i) begin
                  temp_pin_cfg_nxt = reg_wr_data_i;
               end
            end
            FTCR_OFS_PIN_FUNC: begin
               if (!cfg_lock_i) begin
                  pin_func_cfg_nxt = reg_wr_data_i;
               end
            end
            default: ;
         endcase
      end
   end

   // Read data lags the address by one cycle; unmapped offsets read zero
   always_comb begin
      case (reg_addr_i)
         FTCR_OFS_PULSE: rd_data_nxt = pulse_cfg_r;
         FTCR_OFS_TEMP_PIN: rd_data_nxt = temp_pin_cfg_r;
         FTCR_OFS_PIN_FUNC: rd_data_nxt = pin_func_cfg_r;
         default: rd_data_nxt = FTCR_ZERO8;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pulse_cfg_r <= FTCR_RST_PULSE;
         temp_pin_cfg_r <= FTCR_RST_TEMP_PIN;
         pin_func_cfg_r <= FTCR_RST_PIN_FUNC;
         rd_data_r <= FTCR_ZERO8;
      end else begin
         pulse_cfg_r <= pulse_cfg_nxt;
         temp_pin_cfg_r <= temp_pin_cfg_nxt;
         pin_func_cfg_r <= pin_func_cfg_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign reg_rd_data_o = rd_data_r;

   // ---------------- Field decode ----------------
   logic twos_complement_sel;
   logic offset_coarse;
   logic shared_io_direction;
   logic shared_io_polarity;
   logic [2:0] limit_enable;
   logic overtemp_output_off;
   logic limit_speed_select;
   ftcr_pin_func_t mux_pin_function;

   assign twos_complement_sel = temp_pin_cfg_r[FTCR_BIT_TWOS];
   assign offset_coarse = temp_pin_cfg_r[FTCR_BIT_OFS_RANGE];
   assign shared_io_direction = temp_pin_cfg_r[FTCR_BIT_IO_DIR];
   assign shared_io_polarity = temp_pin_cfg_r[FTCR_BIT_IO_POL];
   assign limit_enable =
      temp_pin_cfg_r[FTCR_BIT_LIM_EN_LO +: FTCR_NUM_CH];
   assign overtemp_output_off = pin_func_cfg_r[FTCR_BIT_OT_OFF];
   assign limit_speed_select = pin_func_cfg_r[FTCR_BIT_SPEED_SEL];
   assign mux_pin_function =
      ftcr_pin_func_t'(pin_func_cfg_r[FTCR_FLD_FUNC_LO +: 2]);

   // These are static settings, so they leave straight from the register
   assign cpu_code_or_io_sel_o = temp_pin_cfg_r[FTCR_BIT_CODE_IO];
   assign bypass_low_rail_atten_o = pin_func_cfg_r[FTCR_BIT_BYP_LO];
   assign bypass_core_rail_atten_o = pin_func_cfg_r[FTCR_BIT_BYP_LO + 1];
   assign bypass_mid_rail_atten_o = pin_func_cfg_r[FTCR_BIT_BYP_LO + 2];
   assign bypass_high_rail_atten_o = pin_func_cfg_r[FTCR_BIT_BYP_LO + 3];

   // ---------------- Fan tachometers ----------------
   logic [3:0] tach_in;

   // Fan 4 only sees its tachometer while the mux pin is set for it
   assign tach_in = {mux_pin_i & (mux_pin_function == FTCR_FUNC_FOURTH_FAN_PULSE_SEL_TACH),
                     fan_tach_i};

   genvar f;
   generate
      for (f = 0; f < FTCR_NUM_FANS; f++) begin : g_fan
         ftcr_tach_meas u_tach (
            .ref_clk_i(ref_clk_i),
            .reset_n_i(reset_n_i),
            .tach_i(tach_in[f]),
            .pulse_sel_i(pulse_cfg_r[f*FTCR_PSEL_W +: FTCR_PSEL_W]),
            .period_o(fan_period_o[f*FTCR_TACH_W +: FTCR_TACH_W]),
            .period_valid_o(fan_period_valid_o[f])
         );
      end
   endgenerate

   // ---------------- Temperature channels ----------------
   logic [26:0] temp_c_r, temp_c_nxt;
   logic [29:0] offset_r, offset_nxt;
   logic [23:0] duty_r, duty_nxt;
   logic [2:0] suppressed;
   logic [2:0] trip;
   logic hot_event;

   assign hot_event = |trip;

   genvar c;
   generate
      for (c = 0; c < FTCR_NUM_CH; c++) begin : g_ch
         // Decode follows the live format bit, no re-write needed
         assign temp_c_nxt[c*FTCR_TEMP_W +: FTCR_TEMP_W] =
            decode_temp(temp_raw_i[c*8 +: 8], twos_complement_sel);
         assign offset_nxt[c*FTCR_OFST_W +: FTCR_OFST_W] =
            scale_offset(offset_raw_i[c*8 +: 8], offset_coarse);
         assign suppressed[c] = twos_complement_sel ?
            (overtemp_limit_i[c*8 +: 8] == FTCR_LIM_MIN_TWOS) :
            (overtemp_limit_i[c*8 +: 8] == FTCR_LIM_MIN_OFS64);
         assign trip[c] = chan_hot_i[c] & limit_enable[c] &
                          ~suppressed[c];
         assign duty_nxt[c*8 +: 8] = !hot_event ? pwm_duty_i[c*8 +: 8] :
            limit_speed_select ? max_duty_i[c*8 +: 8] :
            FTCR_FULL_DUTY;
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         temp_c_r <= '0;
         offset_r <= '0;
         duty_r <= '0;
      end else begin
         temp_c_r <= temp_c_nxt;
         offset_r <= offset_nxt;
         duty_r <= duty_nxt;
      end
   end

   assign temp_c_o = temp_c_r;
   assign offset_half_o = offset_r;
   assign pwm_duty_o = duty_r;

   // ---------------- Pins ----------------
   logic ot_drive;
   logic ot_oe_n_r, ot_oe_n_nxt;
   logic mux_out_r, mux_out_nxt;
   logic mux_oe_n_r, mux_oe_n_nxt;
   logic io_level_r, io_level_nxt;
   logic ot_seen_r, ot_seen_nxt;

   // The disable bit gates only the overtemperature pin and the mux pin's overtemp drive; fan boost still follows the trip
   assign ot_drive = hot_event & ~overtemp_output_off;

   always_comb begin
      ot_oe_n_nxt = ~ot_drive;
      mux_out_nxt = 1'b0;
      mux_oe_n_nxt = 1'b1;
      io_level_nxt = 1'b0;
      // Pin is active low, so an outside pull-down reads as assertion
      ot_seen_nxt = ~overtemp_pin_i;
      case (mux_pin_function)
         FTCR_FUNC_FOURTH_FAN_PULSE_SEL_TACH: mux_oe_n_nxt = 1'b1;
         FTCR_FUNC_OVERTEMP: begin
            mux_oe_n_nxt = ~ot_drive;
            ot_seen_nxt = ~overtemp_pin_i | ~mux_pin_i;
         end
         FTCR_FUNC_ALERT: mux_oe_n_nxt = ~alert_req_i;
         FTCR_FUNC_IO: begin
            if (shared_io_direction) begin
               mux_oe_n_nxt = 1'b0;
               mux_out_nxt = shared_io_polarity ? shared_io_data_i :
                             ~shared_io_data_i;
            end else begin
               io_level_nxt = mux_pin_i;
            end
         end
         default: mux_oe_n_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ot_oe_n_r <= 1'b1;
         mux_out_r <= 1'b0;
         mux_oe_n_r <= 1'b1;
         io_level_r <= 1'b0;
         ot_seen_r <= 1'b0;
      end else begin
         ot_oe_n_r <= ot_oe_n_nxt;
         mux_out_r <= mux_out_nxt;
         mux_oe_n_r <= mux_oe_n_nxt;
         io_level_r <= io_level_nxt;
         ot_seen_r <= ot_seen_nxt;
      end
   end

   // Open drain: only ever pulls low
   assign overtemp_pin_o = 1'b0;
   assign overtemp_pin_oe_n_o = ot_oe_n_r;
   assign mux_pin_o = mux_out_r;
   assign mux_pin_oe_n_o = mux_oe_n_r;
   assign shared_io_level_o = io_level_r;
   assign overtemp_asserted_o = ot_seen_r;

   // ---------------- Checks ----------------
   a_lock_temp_hold: assert property (
      cfg_lock_i && reg_wr_en_i && reg_addr_i == FTCR_OFS_TEMP_PIN
      |=> $stable(temp_pin_cfg_r))
      else $error("locked temperature config changed");

   a_lock_func_hold: assert property (
      cfg_lock_i && reg_wr_en_i && reg_addr_i == FTCR_OFS_PIN_FUNC
      |=> $stable(pin_func_cfg_r))
      else $error("locked pin function config changed");

   a_pulse_write_rd: assert property (
      reg_wr_en_i && reg_addr_i == FTCR_OFS_PULSE ##1
      reg_addr_i == FTCR_OFS_PULSE
      |=> reg_rd_data_o == $past(reg_wr_data_i, 2))
      else $error("pulse register readback mismatch");

   property p_reset_vals;
      @(posedge ref_clk_i) disable iff (1'b0)
      !reset_n_i |=> pulse_cfg_r == FTCR_RST_PULSE &&
         temp_pin_cfg_r == FTCR_RST_TEMP_PIN &&
         pin_func_cfg_r == FTCR_RST_PIN_FUNC;
   endproperty
   a_reset_values: assert property (p_reset_vals)
      else $error("power-on register values wrong");

   a_off_quiet: assert property (
      overtemp_output_off |=> overtemp_pin_oe_n_o)
      else $error("overtemperature pin driven while disabled");

   a_trip_drive: assert property (
      (chan_hot_i & limit_enable & ~suppressed) != 3'b000 &&
      !overtemp_output_off |=> !overtemp_pin_oe_n_o)
      else $error("enabled channel failed to drive pin");

   a_min_limit_off: assert property (
      twos_complement_sel && chan_hot_i == 3'b001 &&
      overtemp_limit_i[7:0] == FTCR_LIM_MIN_TWOS |=> overtemp_pin_oe_n_o)
      else $error("minimum limit did not silence channel");

   a_full_speed: assert property (
      hot_event && !limit_speed_select
      |=> pwm_duty_o == {3{FTCR_FULL_DUTY}})
      else $error("fans not at full speed on overtemperature");

   a_twos_decode: assert property (
      twos_complement_sel
      |=> temp_c_o[8:0] == {$past(temp_raw_i[7]), $past(temp_raw_i[7:0])})
      else $error("twos complement decode wrong");

   a_io_polarity: assert property (
      mux_pin_function == FTCR_FUNC_IO && shared_io_direction &&
      !shared_io_polarity |=> !mux_pin_oe_n_o &&
      mux_pin_o == !$past(shared_io_data_i))
      else $error("active-low shared output wrong");

   c_locked_write: cover property (
      cfg_lock_i && reg_wr_en_i && reg_addr_i == FTCR_OFS_TEMP_PIN);
   c_overtemp_drive: cover property (!overtemp_pin_oe_n_o);
   c_fan_period: cover property (fan_period_valid_o[0]);
endmodule : ftcr_cfg_regs

/* rtl/ftcr_pkg.sv */
// Shared constants and types for the fan and thermal configuration bank
package ftcr_pkg;
   // Register offsets on the internal register port
   localparam logic [7:0] FTCR_OFS_PULSE = 8'h7B;
   localparam logic [7:0] FTCR_OFS_TEMP_PIN = 8'h7C;
   localparam logic [7:0] FTCR_OFS_PIN_FUNC = 8'h7D;
   // Power-on values
   localparam logic [7:0] FTCR_RST_PULSE = 8'h55;
   localparam logic [7:0] FTCR_RST_TEMP_PIN = 8'h01;
   localparam logic [7:0] FTCR_RST_PIN_FUNC = 8'h00;
   localparam logic [7:0] FTCR_ZERO8 = 8'h00;
   // Temperature and pin configuration fields
   localparam int FTCR_BIT_TWOS = 0;
   localparam int FTCR_BIT_OFS_RANGE = 1;
   localparam int FTCR_BIT_IO_DIR = 2;
   localparam int FTCR_BIT_IO_POL = 3;
   localparam int FTCR_BIT_CODE_IO = 4;
   localparam int FTCR_BIT_LIM_EN_LO = 5;
   // Pin function and attenuator fields
   localparam int FTCR_FLD_FUNC_LO = 0;
   localparam int FTCR_BIT_OT_OFF = 2;
   localparam int FTCR_BIT_SPEED_SEL = 3;
   localparam int FTCR_BIT_BYP_LO = 4;
   // Sizes
   localparam int FTCR_NUM_FANS = 4;
   localparam int FTCR_NUM_CH = 3;
   localparam int FTCR_PSEL_W = 2;
   localparam int FTCR_TACH_W = 16;
   localparam int FTCR_TEMP_W = 9;
   localparam int FTCR_OFST_W = 10;
   // Overtemperature limit codes that mean "channel off"
   localparam logic [7:0] FTCR_LIM_MIN_OFS64 = 8'h00;
   localparam logic [7:0] FTCR_LIM_MIN_TWOS = 8'h80;
   localparam logic [8:0] FTCR_OFS64_BIAS = 9'h040;
   localparam logic [7:0] FTCR_FULL_DUTY = 8'hFF;
   localparam logic [15:0] FTCR_TACH_MAX = 16'hFFFF;
   localparam logic [15:0] FTCR_TACH_ONE = 16'h0001;
   localparam logic [1:0] FTCR_PSEL_ZERO = 2'h0;
   localparam logic [1:0] FTCR_PSEL_ONE = 2'h1;

   typedef enum logic [1:0] {
      FTCR_FUNC_FOURTH_FAN_PULSE_SEL_TACH = 2'b00,
      FTCR_FUNC_OVERTEMP = 2'b01,
      FTCR_FUNC_ALERT = 2'b10,
      FTCR_FUNC_IO = 2'b11
   } ftcr_pin_func_t;

   typedef enum logic {
      FTCR_TS_WAIT = 1'b0,
      FTCR_TS_TIME = 1'b1
   } ftcr_tach_st_t;
endpackage : ftcr_pkg

/* rtl/ftcr_tach_meas.sv */
// Per-fan tachometer period timer over a selectable number of pulses
`timescale 1ns/1ns
module ftcr_tach_meas
   import ftcr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Tachometer input and pulse count code
   input wire logic tach_i,
   input wire logic [FTCR_PSEL_W-1:0] pulse_sel_i,
   // Measurement result
   output logic [FTCR_TACH_W-1:0] period_o,
   output logic period_valid_o
);
   ftcr_tach_st_t st_r, st_nxt;
   logic tach_prev_r, tach_prev_nxt;
   logic [FTCR_TACH_W-1:0] cnt_r, cnt_nxt;
   logic [FTCR_TACH_W-1:0] per_r, per_nxt;
   logic [FTCR_PSEL_W-1:0] edges_r, edges_nxt;
   logic vld_r, vld_nxt;
   logic rise;

   assign rise = tach_i & ~tach_prev_r;

   // Code n spans n+1 pulses: start edge plus n+1 further rising edges
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      per_nxt = per_r;
      edges_nxt = edges_r;
      vld_nxt = 1'b0;
      tach_prev_nxt = tach_i;
      case (st_r)
         FTCR_TS_WAIT: begin
            if (rise) begin
               st_nxt = FTCR_TS_TIME;
               cnt_nxt = FTCR_TACH_ONE;
               edges_nxt = FTCR_PSEL_ZERO;
            end
         end
         FTCR_TS_TIME: begin
            if (rise && edges_r == pulse_sel_i) begin
               per_nxt = cnt_r;
               vld_nxt = 1'b1;
               cnt_nxt = FTCR_TACH_ONE;
               edges_nxt = FTCR_PSEL_ZERO;
            end else if (cnt_r == FTCR_TACH_MAX) begin
               // Stalled fan: report full scale and rearm; checked before
               // a mid-window edge so the counter can never wrap
               per_nxt = FTCR_TACH_MAX;
               vld_nxt = 1'b1;
               st_nxt = FTCR_TS_WAIT;
            end else if (rise) begin
               edges_nxt = edges_r + FTCR_PSEL_ONE;
               cnt_nxt = cnt_r + FTCR_TACH_ONE;
            end else begin
               cnt_nxt = cnt_r + FTCR_TACH_ONE;
            end
         end
         default: st_nxt = FTCR_TS_WAIT;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         st_r <= FTCR_TS_WAIT;
         cnt_r <= '0;
         per_r <= FTCR_TACH_MAX;
         edges_r <= FTCR_PSEL_ZERO;
         vld_r <= 1'b0;
         tach_prev_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         per_r <= per_nxt;
         edges_r <= edges_nxt;
         vld_r <= vld_nxt;
         tach_prev_r <= tach_prev_nxt;
      end
   end

   assign period_o = per_r;
   assign period_valid_o = vld_r;
endmodule : ftcr_tach_meas

/* verif/ftcr_cfg_regs_test.sv */
// Self-checking bench for the fan and thermal configuration bank
`timescale 1ns/1ns
module ftcr_cfg_regs_test;
   import ftcr_pkg::*;
   localparam int TP = 10;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_en_i = 1'b0;
   logic [7:0] reg_wr_data_i = 8'h00;
   logic cfg_lock_i = 1'b0;
   logic [2:0] fan_tach_i = 3'h0;
   logic [23:0] temp_raw_i = 24'h0;
   logic [23:0] offset_raw_i = 24'h0;
   logic [2:0] chan_hot_i = 3'h0;
   logic [23:0] overtemp_limit_i = 24'h0;
   logic alert_req_i = 1'b0;
   logic shared_io_data_i = 1'b0;
   logic [23:0] pwm_duty_i = 24'h0;
   logic [23:0] max_duty_i = 24'h0;
   logic ot_ext = 1'b1;
   logic mux_ext = 1'b0;
   wire logic overtemp_pin_i;
   wire logic mux_pin_i;
   wire logic [7:0] reg_rd_data_o;
   wire logic [63:0] fan_period_o;
   wire logic [3:0] fan_period_valid_o;
   wire logic [26:0] temp_c_o;
   wire logic [29:0] offset_half_o;
   wire logic overtemp_asserted_o, overtemp_pin_o, overtemp_pin_oe_n_o;
   wire logic mux_pin_o, mux_pin_oe_n_o, shared_io_level_o;
   wire logic [23:0] pwm_duty_o;
   wire logic cpu_code_or_io_sel_o, bypass_low_rail_atten_o;
   wire logic bypass_core_rail_atten_o, bypass_mid_rail_atten_o;
   wire logic bypass_high_rail_atten_o;
   int num_errors = 0;
   int num_checks = 0;
   int seed = 32'h1BAF;
   logic [7:0] m_reg [3] = '{8'h55, 8'h01, 8'h00};

   // Open-drain wires: a driving end wins over the outside level
   assign overtemp_pin_i = overtemp_pin_oe_n_o ? ot_ext : 1'b0;
   assign mux_pin_i = mux_pin_oe_n_o ? mux_ext : mux_pin_o;

   always #5 ref_clk_i = ~ref_clk_i;

   ftcr_cfg_regs u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_en_i(reg_wr_en_i),
      .reg_wr_data_i(reg_wr_data_i), .cfg_lock_i(cfg_lock_i),
      .reg_rd_data_o(reg_rd_data_o), .fan_tach_i(fan_tach_i),
      .fan_period_o(fan_period_o), .fan_period_valid_o(fan_period_valid_o),
      .temp_raw_i(temp_raw_i), .temp_c_o(temp_c_o),
      .offset_raw_i(offset_raw_i), .offset_half_o(offset_half_o),
      .chan_hot_i(chan_hot_i), .overtemp_limit_i(overtemp_limit_i),
      .overtemp_asserted_o(overtemp_asserted_o),
      .overtemp_pin_i(overtemp_pin_i), .overtemp_pin_o(overtemp_pin_o),
      .overtemp_pin_oe_n_o(overtemp_pin_oe_n_o), .mux_pin_i(mux_pin_i),
      .mux_pin_o(mux_pin_o), .mux_pin_oe_n_o(mux_pin_oe_n_o),
      .alert_req_i(alert_req_i), .shared_io_data_i(shared_io_data_i),
      .shared_io_level_o(shared_io_level_o), .pwm_duty_i(pwm_duty_i),
      .max_duty_i(max_duty_i), .pwm_duty_o(pwm_duty_o),
      .cpu_code_or_io_sel_o(cpu_code_or_io_sel_o),
      .bypass_low_rail_atten_o(bypass_low_rail_atten_o),
      .bypass_core_rail_atten_o(bypass_core_rail_atten_o),
      .bypass_mid_rail_atten_o(bypass_mid_rail_atten_o),
      .bypass_high_rail_atten_o(bypass_high_rail_atten_o));

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wr_data_i <= d;
      reg_wr_en_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_en_i <= 1'b0;
      // Only the pulse count register stays writable under the lock
      if (a == 8'h7B || (!cfg_lock_i && (a == 8'h7C || a == 8'h7D))) begin
         m_reg[a - 8'h7B] = d;
      end
   endtask : reg_wr

   task automatic reg_rd_all;
      for (int a = 8'h7A; a <= 8'h7E; a++) begin
         @(posedge ref_clk_i);
         reg_addr_i <= 8'(a);
         @(posedge ref_clk_i);
         #1;
         chk("reg_rd_data_o", reg_rd_data_o,
             (a >= 8'h7B && a <= 8'h7D) ? m_reg[a - 8'h7B] : 8'h00);
      end
   endtask : reg_rd_all

   task automatic tach_round(input logic [7:0] code);
      int n[4] = '{0, 0, 0, 0};
      reg_wr(FTCR_OFS_PIN_FUNC, 8'h00);
      reg_wr(FTCR_OFS_PULSE, code);
      for (int c = 0; c < 16 * TP; c++) begin
         @(posedge ref_clk_i);
         fan_tach_i <= {3{(c % TP) < 2}};
         mux_ext <= (c % TP) < 2;
         #1;
         for (int f = 0; f < 4; f++) begin
            if (fan_period_valid_o[f] === 1'b1) begin
               n[f]++;
               // First result may straddle the code change, so skip it
               if (n[f] == 2) begin
                  chk("fan_period_o", fan_period_o[16*f+:16],
                      (32'(code[2*f+:2]) + 1) * TP);
               end
            end
         end
      end
      for (int f = 0; f < 4; f++) begin
         chk("fan_period_count", 32'(n[f] >= 2), 32'h1);
      end
   endtask : tach_round

   task automatic check_all;
      logic [7:0] c5, c4, t, o, lim;
      logic trip, ot_oe, mux_oe, mux_o, otw, mxw;
      logic [26:0] te;
      logic [29:0] oe;
      logic [23:0] pe;
      c5 = m_reg[1];
      c4 = m_reg[2];
      trip = 1'b0;
      for (int ch = 0; ch < 3; ch++) begin
         t = temp_raw_i[8*ch+:8];
         o = offset_raw_i[8*ch+:8];
         lim = overtemp_limit_i[8*ch+:8];
         te[9*ch+:9] = c5[0] ? {t[7], t} : {1'b0, t} - 9'h040;
         oe[10*ch+:10] = c5[1] ? {o[7], o, 1'b0} : {{2{o[7]}}, o};
         if (chan_hot_i[ch] && c5[5+ch] &&
             lim != (c5[0] ? 8'h80 : 8'h00)) begin
            trip = 1'b1;
         end
      end
      for (int ch = 0; ch < 3; ch++) begin
         pe[8*ch+:8] = !trip ? pwm_duty_i[8*ch+:8] :
                       (c4[3] ? max_duty_i[8*ch+:8] : 8'hFF);
      end
      ot_oe = !(trip && !c4[2]);
      mux_o = (c4[1:0] == 2'b11 && c5[2]) ? (c5[3] ? shared_io_data_i
                                                   : !shared_io_data_i) : 1'b0;
      case (c4[1:0])
         2'b00: mux_oe = 1'b1;
         2'b01: mux_oe = ot_oe;
         2'b10: mux_oe = !alert_req_i;
         default: mux_oe = !c5[2];
      endcase
      otw = ot_oe ? ot_ext : 1'b0;
      mxw = mux_oe ? mux_ext : mux_o;
      chk("temp_c_o", temp_c_o, te);
      chk("offset_half_o", offset_half_o, oe);
      chk("overtemp_pin_oe_n_o", overtemp_pin_oe_n_o, ot_oe);
      chk("pwm_duty_o", pwm_duty_o, pe);
      chk("mux_pin_oe_n_o", mux_pin_oe_n_o, mux_oe);
      chk("mux_pin_o", mux_pin_o, mux_o);
      chk("overtemp_pin_o", overtemp_pin_o, 1'b0);
      chk("shared_io_level_o", shared_io_level_o,
          (c4[1:0] == 2'b11 && !c5[2]) ? mxw : 1'b0);
      chk("overtemp_asserted_o", overtemp_asserted_o,
          !otw || (c4[1:0] == 2'b01 && !mxw));
      chk("cpu_code_or_io_sel_o", cpu_code_or_io_sel_o, c5[4]);
      chk("bypass_atten", {bypass_high_rail_atten_o, bypass_mid_rail_atten_o,
          bypass_core_rail_atten_o, bypass_low_rail_atten_o}, c4[7:4]);
   endtask : check_all

   task automatic results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (12) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      reg_rd_all();
      // No tach edge yet, so every period still shows its power-on value
      for (int f = 0; f < 4; f++) begin
         chk("fan_period_reset", fan_period_o[16*f+:16], 32'hFFFF);
      end
      chk("fan_valid_reset", fan_period_valid_o, 32'h0);
      tach_round(8'h1B);
      tach_round(8'hE4);
      for (int it = 0; it < 48; it++) begin
         @(posedge ref_clk_i);
         cfg_lock_i <= (it % 4) == 3;
         reg_wr(FTCR_OFS_PULSE, 8'($random(seed)));
         reg_wr(FTCR_OFS_TEMP_PIN, 8'($random(seed)));
         reg_wr(FTCR_OFS_PIN_FUNC, 8'($random(seed)));
         @(posedge ref_clk_i);
         temp_raw_i <= 24'($random(seed));
         offset_raw_i <= 24'($random(seed));
         chan_hot_i <= 3'($random(seed));
         // Half the limits sit on the channel-off code of either format
         for (int ch = 0; ch < 3; ch++) begin
            overtemp_limit_i[8*ch+:8] <= ($random(seed) & 1) ?
               ((it % 2) ? 8'h80 : 8'h00) : 8'($random(seed));
         end
         alert_req_i <= 1'($random(seed));
         shared_io_data_i <= 1'($random(seed));
         pwm_duty_i <= 24'($random(seed));
         max_duty_i <= 24'($random(seed));
         ot_ext <= 1'($random(seed));
         mux_ext <= 1'($random(seed));
         repeat (4) @(posedge ref_clk_i);
         #1;
         check_all();
         reg_rd_all();
      end
      results();
   end
endmodule : ftcr_cfg_regs_test
